// ---- qpio_pkg.sv ----
// Package for the quad parallel I/O ports: register offsets, widths and reset values.
// Assumes a byte-wide register port with an 8-bit address field.
package qpio_pkg;
    localparam int QPIO_DATA_W = 8;
    localparam int QPIO_ADDR_W = 8;
    localparam int QPIO_NUM_PORTS = 4;
    // Register offsets
    localparam logic [7:0] QPIO_PORT_A_DATA = 8'h00;
    localparam logic [7:0] QPIO_PORT_B_DATA = 8'h01;
    localparam logic [7:0] QPIO_PORT_C_DATA = 8'h02;
    localparam logic [7:0] QPIO_PORT_D_DATA = 8'h03;
    localparam logic [7:0] QPIO_PORT_A_DIRECTION = 8'h04;
    localparam logic [7:0] QPIO_PORT_B_DIRECTION = 8'h05;
    localparam logic [7:0] QPIO_PORT_C_DIRECTION = 8'h06;
    localparam logic [7:0] QPIO_PORT_D_DIRECTION = 8'h07;
    // Field positions and reset values
    localparam int QPIO_COMPARE_BIT = 6;
    localparam logic [7:0] QPIO_DIR_RESET = 8'h00;
    localparam logic [7:0] QPIO_DATA_INIT = 8'h00;
    localparam logic [7:0] QPIO_UNMAPPED_READ = 8'h00;
endpackage : qpio_pkg

// ---- qpio_reg_if.sv ----
// Interface carrying one port's latch, direction and pin signals to a port slice.
// Assumes a single clock domain; used only inside the I/O port block.
interface qpio_reg_if;
    import qpio_pkg::*;
    logic [QPIO_DATA_W-1:0] latchQ;
    logic [QPIO_DATA_W-1:0] dirQ;
    logic [QPIO_DATA_W-1:0] altEn;
    logic [QPIO_DATA_W-1:0] altOut;
    logic [QPIO_DATA_W-1:0] pinIn;
    logic [QPIO_DATA_W-1:0] pinOut;
    logic [QPIO_DATA_W-1:0] pinOeN;
    logic [QPIO_DATA_W-1:0] readVal;
    modport core (output latchQ, dirQ, altEn, altOut, pinIn, input pinOut, pinOeN, readVal);
    modport slice (input latchQ, dirQ, altEn, altOut, pinIn, output pinOut, pinOeN, readVal);
endinterface : qpio_reg_if

// ---- qpio_port_slice.sv ----
// One 8-bit port slice: output mux, pin drive enables and read-back mux.
// Assumes pin inputs already synchronous to sys_clk.
module qpio_port_slice
    import qpio_pkg::*;
(
    // Port signals
    qpio_reg_if.slice port
);
    // Alternate unit drive replaces the latch, direction still gates the pin
    assign port.pinOut = (port.altEn & port.altOut) | (~port.altEn & port.latchQ);
    assign port.pinOeN = ~port.dirQ;
    // Outputs read the latch, inputs and unit-driven pins read the pin level
    assign port.readVal = (port.dirQ & ~port.altEn & port.latchQ)
        | (~(port.dirQ & ~port.altEn) & port.pinIn);
endmodule : qpio_port_slice

// ---- qpio_ports.sv ----
// Top of the quad parallel I/O ports: four 8-bit ports behind a byte register port.
// Assumes a master issuing one-cycle strobes; read data valid the cycle after a read.
// Port D shares pins with timer, serial and PWM units through unitEn/unitOut inputs.
//
// Design decision made here: the address-and-strobe port.
module qpio_ports
    import qpio_pkg::*;
(
    // Clock, enable and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // Register port
    input wire logic [QPIO_ADDR_W-1:0] regAddr,
    input wire logic [QPIO_DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [QPIO_DATA_W-1:0] regRdata,
    // Port A pins
    input wire logic [QPIO_DATA_W-1:0] portAIn,
    output logic [QPIO_DATA_W-1:0] portAOut,
    output logic [QPIO_DATA_W-1:0] portAOeN,
    // Port B pins
    input wire logic [QPIO_DATA_W-1:0] portBIn,
    output logic [QPIO_DATA_W-1:0] portBOut,
    output logic [QPIO_DATA_W-1:0] portBOeN,
    // Port C pins
    input wire logic [QPIO_DATA_W-1:0] portCIn,
    output logic [QPIO_DATA_W-1:0] portCOut,
    output logic [QPIO_DATA_W-1:0] portCOeN,
    // Port D pins, fourth_port_pins
    input wire logic [QPIO_DATA_W-1:0] fourthPortPinsIn,
    output logic [QPIO_DATA_W-1:0] fourthPortPinsOut,
    output logic [QPIO_DATA_W-1:0] fourthPortPinsOeN,
    // On-chip units sharing port D
    input wire logic [QPIO_DATA_W-1:0] unitEn,
    input wire logic [QPIO_DATA_W-1:0] unitOut,
    input wire logic timerComparePin
);
    logic [QPIO_DATA_W-1:0] latchQ [QPIO_NUM_PORTS];
    logic [QPIO_DATA_W-1:0] dirQ [QPIO_NUM_PORTS];
    logic [QPIO_DATA_W-1:0] readVal [QPIO_NUM_PORTS];
    logic [QPIO_DATA_W-1:0] pinIn [QPIO_NUM_PORTS];
    logic [QPIO_DATA_W-1:0] pinOut [QPIO_NUM_PORTS];
    logic [QPIO_DATA_W-1:0] pinOeN [QPIO_NUM_PORTS];
    logic [QPIO_DATA_W-1:0] dMask;
    logic [QPIO_DATA_W-1:0] regRdata_d;
    logic [QPIO_DATA_W-1:0] regRdata_q;
    logic isData;
    logic isDir;
    logic [1:0] portSel;
    logic [QPIO_NUM_PORTS-1:0] latchSeen_q;

    // Address decode: offsets 0-3 are latches, 4-7 are direction registers
    assign isData = (regAddr >= QPIO_PORT_A_DATA) && (regAddr <= QPIO_PORT_D_DATA);
    assign isDir = (regAddr >= QPIO_PORT_A_DIRECTION) && (regAddr <= QPIO_PORT_D_DIRECTION);
    assign portSel = regAddr[1:0];

    // Bit 6 of port D has no direction storage
    assign dMask = ~(QPIO_DATA_W'(1) << QPIO_COMPARE_BIT);

    // Data latches are not reset, so they hold across a reset pulse
    always_ff @(posedge sys_clk)
    begin
        if (clkEn && regWrite && isData)
        begin
            latchQ[portSel] <= regWdata;
        end
    end

    // Direction registers clear on reset so every pin except port D bit 6 (always an output) starts as an input
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < QPIO_NUM_PORTS; i++)
            begin
                dirQ[i] <= QPIO_DIR_RESET;
            end
        end
        else if (clkEn && regWrite && isDir)
        begin
            if (portSel == 2'h3)
            begin
                dirQ[portSel] <= regWdata & dMask;
            end
            else
            begin
                dirQ[portSel] <= regWdata;
            end
        end
    end

    // Pin inputs per port
    assign pinIn[0] = portAIn;
    assign pinIn[1] = portBIn;
    assign pinIn[2] = portCIn;
    assign pinIn[3] = fourthPortPinsIn;

    // Four identical port slices; only port D has alternate unit drive
    generate
        for (genvar g = 0; g < QPIO_NUM_PORTS; g++)
        begin : gPort
            qpio_reg_if pif();
            assign pif.latchQ = latchQ[g];
            assign pif.pinIn = pinIn[g];
            if (g == QPIO_NUM_PORTS - 1)
            begin : gShared
                // Bit 6 forced to unit drive and always enabled as output
                assign pif.dirQ = dirQ[g] | ~dMask;
                assign pif.altEn = unitEn | ~dMask;
                assign pif.altOut = (unitOut & dMask)
                    | ({QPIO_DATA_W{timerComparePin}} & ~dMask);
            end
            else
            begin : gPlain
                assign pif.dirQ = dirQ[g];
                assign pif.altEn = '0;
                assign pif.altOut = '0;
            end
            qpio_port_slice uSlice (
                .port(pif.slice)
            );
            assign readVal[g] = pif.readVal;
            assign pinOut[g] = pif.pinOut;
            assign pinOeN[g] = pif.pinOeN;
        end
    endgenerate

    // Pin outputs, 31 bidirectional plus the compare-only line
    assign portAOut = pinOut[0];
    assign portAOeN = pinOeN[0];
    assign portBOut = pinOut[1];
    assign portBOeN = pinOeN[1];
    assign portCOut = pinOut[2];
    assign portCOeN = pinOeN[2];
    assign fourthPortPinsOut = pinOut[3];
    assign fourthPortPinsOeN = pinOeN[3];

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        regRdata_d = QPIO_UNMAPPED_READ;
        if (isData)
        begin
            regRdata_d = readVal[portSel];
        end
        else if (isDir)
        begin
            regRdata_d = dirQ[portSel];
        end
    end

    // Read data registered; stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            regRdata_q <= QPIO_UNMAPPED_READ;
        end
        else if (clkEn)
        begin
            regRdata_q <= regRead ? regRdata_d : QPIO_UNMAPPED_READ;
        end
    end
    assign regRdata = regRdata_q;

    // Check aid: latches power up unknown, so checks on them wait for a first write
    always_ff @(posedge sys_clk)
    begin
        if (clkEn && regWrite && isData)
        begin
            latchSeen_q[portSel] <= 1'b1;
        end
    end

    // Reset and direction storage
    AST_DIR_RESET: assert property (
        @(posedge sys_clk) !reset_n |=> (dirQ[0] == QPIO_DIR_RESET && dirQ[1] == QPIO_DIR_RESET
        && dirQ[2] == QPIO_DIR_RESET && dirQ[3] == QPIO_DIR_RESET))
        else $error("direction not cleared by reset");
    AST_DIR6_NONE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        dirQ[3][QPIO_COMPARE_BIT] == 1'b0)
        else $error("port D direction bit 6 stored");
    AST_DIR_WRITE_A: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regWrite && regAddr == QPIO_PORT_A_DIRECTION) |=> dirQ[0] == $past(regWdata))
        else $error("port A direction write lost");
    AST_DIR_WRITE_B: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regWrite && regAddr == QPIO_PORT_B_DIRECTION) |=> dirQ[1] == $past(regWdata))
        else $error("port B direction write lost");
    AST_DIR_WRITE_D: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regWrite && regAddr == QPIO_PORT_D_DIRECTION)
        |=> dirQ[3] == ($past(regWdata) & dMask))
        else $error("port D direction write lost");
    AST_DIR_RW: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regWrite && regAddr == QPIO_PORT_C_DIRECTION) ##1
        (clkEn && regRead && regAddr == QPIO_PORT_C_DIRECTION && !$past(regRead))
        |=> regRdata == $past(dirQ[2]))
        else $error("direction read back wrong");
    // A frozen clock enable must hold the port A and port D direction registers and the read data
    AST_FREEZE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !clkEn |=> ($stable(dirQ[0]) && $stable(dirQ[3]) && $stable(regRdata)))
        else $error("state moved while clock enable low");

    // Pin drive and direction gating
    AST_OUT_DRIVE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        dirQ[0][0] |-> (portAOeN[0] == 1'b0 && portAOut[0] == latchQ[0][0]))
        else $error("output pin not driving latch");
    AST_IN_FLOAT: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !dirQ[1][3] |-> portBOeN[3])
        else $error("input pin is driving");
    AST_ENABLE_A: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        portAOeN == ~dirQ[0])
        else $error("port A drive enable differs from direction");
    AST_ENABLE_B: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        portBOeN == ~dirQ[1])
        else $error("port B drive enable differs from direction");
    AST_ENABLE_C: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        portCOeN == ~dirQ[2])
        else $error("port C drive enable differs from direction");
    AST_ENABLE_D: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (fourthPortPinsOeN & dMask) == (~dirQ[3] & dMask))
        else $error("port D drive enable differs from direction");

    // Latch writes and retention across reset
    AST_LATCH_WRITE_A: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regWrite && regAddr == QPIO_PORT_A_DATA) |=> latchQ[0] == $past(regWdata))
        else $error("port A latch not updated by write");
    AST_LATCH_WRITE_B: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regWrite && regAddr == QPIO_PORT_B_DATA) |=> latchQ[1] == $past(regWdata))
        else $error("port B latch not updated by write");
    AST_LATCH_WRITE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regWrite && regAddr == QPIO_PORT_C_DATA) |=> latchQ[2] == $past(regWdata))
        else $error("latch not updated by write");
    AST_LATCH_WRITE_D: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regWrite && regAddr == QPIO_PORT_D_DATA) |=> latchQ[3] == $past(regWdata))
        else $error("port D latch not updated by write");
    // The plain ports always present the latch, the direction only gates the pad
    AST_LATCH_OUT_A: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        latchSeen_q[0] |-> portAOut == latchQ[0])
        else $error("port A output does not follow its latch");
    AST_LATCH_OUT_B: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        latchSeen_q[1] |-> portBOut == latchQ[1])
        else $error("port B output does not follow its latch");
    AST_LATCH_OUT_C: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        latchSeen_q[2] |-> portCOut == latchQ[2])
        else $error("port C output does not follow its latch");
    // No reset qualifier here: the latches must ride through a reset pulse untouched
    AST_LATCH_HOLD: assert property (
        @(posedge sys_clk)
        (latchSeen_q[0] && !(clkEn && regWrite && regAddr == QPIO_PORT_A_DATA))
        |=> $stable(latchQ[0]))
        else $error("latch changed without write");
    AST_LATCH_HOLD_B: assert property (
        @(posedge sys_clk)
        (latchSeen_q[1] && !(clkEn && regWrite && regAddr == QPIO_PORT_B_DATA))
        |=> $stable(latchQ[1]))
        else $error("port B latch changed without write");
    AST_LATCH_HOLD_C: assert property (
        @(posedge sys_clk)
        (latchSeen_q[2] && !(clkEn && regWrite && regAddr == QPIO_PORT_C_DATA))
        |=> $stable(latchQ[2]))
        else $error("port C latch changed without write");
    AST_LATCH_HOLD_D: assert property (
        @(posedge sys_clk)
        (latchSeen_q[3] && !(clkEn && regWrite && regAddr == QPIO_PORT_D_DATA))
        |=> $stable(latchQ[3]))
        else $error("port D latch changed without write");

    // Read path
    AST_READ_LATCH: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regRead && regAddr == QPIO_PORT_A_DATA && dirQ[0] == 8'hff)
        |=> regRdata == $past(latchQ[0]))
        else $error("output read did not return latch");
    AST_READ_PIN: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regRead && regAddr == QPIO_PORT_B_DATA && dirQ[1] == 8'h00)
        |=> regRdata == $past(portBIn))
        else $error("input read did not return pin");
    AST_DIR_READ_D: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regRead && regAddr == QPIO_PORT_D_DIRECTION)
        |=> (regRdata == $past(dirQ[3]) && regRdata[QPIO_COMPARE_BIT] == 1'b0))
        else $error("port D direction read back wrong");
    AST_UNMAPPED_READ: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regRead && regAddr > QPIO_PORT_D_DIRECTION)
        |=> regRdata == QPIO_UNMAPPED_READ)
        else $error("unmapped address returned data");

    // Shared port D pins
    AST_COMPARE_PIN: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        fourthPortPinsOut[QPIO_COMPARE_BIT] == timerComparePin
        && !fourthPortPinsOeN[QPIO_COMPARE_BIT])
        else $error("compare pin not driven by timer");
    AST_COMPARE_READ: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regRead && regAddr == QPIO_PORT_D_DATA)
        |=> regRdata[QPIO_COMPARE_BIT] == $past(fourthPortPinsIn[QPIO_COMPARE_BIT]))
        else $error("compare bit did not read pin");
    AST_UNIT_DRIVE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        unitEn[0] |-> fourthPortPinsOut[0] == unitOut[0])
        else $error("unit does not drive shared pin");
    AST_UNIT_DIR: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (unitEn[1] && !dirQ[3][1]) |-> fourthPortPinsOeN[1])
        else $error("unit pin drives with direction cleared");
    AST_UNIT_DIR_SET: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (unitEn[3] && dirQ[3][3])
        |-> (!fourthPortPinsOeN[3] && fourthPortPinsOut[3] == unitOut[3]))
        else $error("unit pin not driven with direction set");
    AST_SHARED_READ: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (clkEn && regRead && regAddr == QPIO_PORT_D_DATA && unitEn[2])
        |=> regRdata[2] == $past(fourthPortPinsIn[2]))
        else $error("shared bit did not read pin");
endmodule : qpio_ports

// ---- qpio_pin_model.sv ----
// Pin-side partner: resolves each pin level from the block's drive.
// Assumes the bench gives the level outside circuits put on undriven pins.
module qpio_pin_model
#(
    parameter int W = 32
)
(
    // Block drive
    input wire logic [W-1:0] pinOut,
    input wire logic [W-1:0] pinOeN,
    // Outside level, changed by the bench so a stale value never reads back
    input wire logic [W-1:0] extLevel,
    // Resolved level
    output logic [W-1:0] pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pin shows the block's value, an input pin the outside level
    assign pinIn = (~pinOeN & pinOut) | (pinOeN & extLevel);
endmodule // qpio_pin_model

// ---- qpio_ports_test.sv ----
// Self-checking bench for the quad parallel I/O ports.
// Assumes the pin model; expected read bytes wait in a queue.
module qpio_ports_test
    import qpio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, reset_n = 0, clkEn = 1, regWrite = 0, regRead = 0, readSeen = 0, timer_compare_pin = 0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, unitEn = 8'h00, unitOut = 8'h00;
    logic [31:0] ext = 32'h0, pinOut, pinOeN, pinIn;
    logic [7:0] latch [4], dir [4], expQ [$];
    int n_errors = 0, checked = 0, cycles = 0;
    qpio_ports u_dut
    (
        .sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .portAIn(pinIn[7:0]), .portAOut(pinOut[7:0]), .portAOeN(pinOeN[7:0]),
        .portBIn(pinIn[15:8]), .portBOut(pinOut[15:8]), .portBOeN(pinOeN[15:8]),
        .portCIn(pinIn[23:16]), .portCOut(pinOut[23:16]), .portCOeN(pinOeN[23:16]),
        .fourthPortPinsIn(pinIn[31:24]), .fourthPortPinsOut(pinOut[31:24]),
        .fourthPortPinsOeN(pinOeN[31:24]), .unitEn(unitEn), .unitOut(unitOut),
        .timerComparePin(timer_compare_pin)
    );
    qpio_pin_model u_pins
    (
        .pinOut(pinOut), .pinOeN(pinOeN), .extLevel(ext), .pinIn(pinIn)
    );
    initial
        forever #2 sys_clk = ~sys_clk;
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Ceiling well above the run's roughly 900 cycles
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            complete_run();
        end
    end
    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk)
        readSeen <= regRead;
    always @(negedge sys_clk)
        if (readSeen)
            check("regRdata", regRdata, expQ.pop_front());
    // Level the pin should carry
    function automatic logic [7:0] pinLvl(int p);
        logic [7:0] dv, de;
        dv = (p == 3) ? ((unitEn & unitOut) | (~unitEn & latch[p])) : latch[p];
        de = dir[p];
        if (p == 3)
        begin
            dv[6] = timer_compare_pin;
            de[6] = 1'b1;
        end
        return (de & dv) | (~de & ext[p*8 +: 8]);
    endfunction
    function automatic logic [7:0] rdExp(int p);
        logic [7:0] fromLatch;
        fromLatch = (p == 3) ? (dir[p] & ~unitEn & 8'hbf) : dir[p];
        return (fromLatch & latch[p]) | (~fromLatch & pinLvl(p));
    endfunction
    // One bus cycle; strobes stay until the next call changes them
    task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] d);
        regWrite <= w;
        regRead <= r;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        if (a < 8'h04)
            latch[a[1:0]] = d;
        else if (a < 8'h08)
            dir[a[1:0]] = (a == 8'h07) ? (d & 8'hbf) : d;
    endtask
    task automatic rd(logic [7:0] a);
        expQ.push_back(a < 8'h04 ? rdExp(a[1:0]) : a < 8'h08 ? dir[a[1:0]] : 8'h00);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask
    // Idle a cycle, then compare every pin and drive enable
    task automatic chkPins();
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        @(negedge sys_clk);
        for (int p = 0; p < 4; p++)
        begin
            check("pin level", pinIn[p*8 +: 8], pinLvl(p));
            check("drive enable", pinOeN[p*8 +: 8], ~(dir[p] | (p == 3 ? 8'h40 : 8'h00)));
        end
        @(posedge sys_clk);
    endtask
    task automatic doReset();
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        reset_n <= 1'b0;
        foreach (dir[p])
            dir[p] = 8'h00;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        chkPins();
        for (int a = 4; a < 8; a++)
            rd(8'(a));
        rd(8'h01);
    endtask
    initial
    begin
        void'($urandom(31));
        doReset();
        $display("test reset done");
        repeat (40)
        begin
            for (int p = 0; p < 4; p++)
                wr(8'(p), 8'($urandom));
            for (int p = 4; p < 8; p++)
                wr(8'(p), 8'($urandom));
            ext <= $urandom;
            unitEn <= 8'($urandom);
            unitOut <= 8'($urandom);
            timer_compare_pin <= 1'($urandom);
            chkPins();
            for (int a = 0; a < 8; a++)
                rd(8'(a));
            rd(8'h08 + 8'($urandom_range(247)));
            wr(8'h06, 8'($urandom));
            rd(8'h06);
        end
        $display("test random access done");
        doReset();
        for (int a = 4; a < 8; a++)
            wr(8'(a), 8'hff);
        for (int a = 0; a < 4; a++)
            rd(8'(a));
        $display("test latch kept over reset done");
        // Writes while frozen must be dropped; the model is left untouched
        clkEn <= 1'b0;
        bus(1'b1, 1'b0, 8'h04, 8'h00);
        bus(1'b1, 1'b0, 8'h00, 8'h5a);
        clkEn <= 1'b1;
        rd(8'h04);
        rd(8'h00);
        $display("test clock enable freeze done");
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h01);
        chkPins();
        wr(8'h04, 8'h00);
        chkPins();
        $display("test open drain done");
        repeat (2) @(posedge sys_clk);
        complete_run();
    end
endmodule // qpio_ports_test
